/* File: rtl/cooler_alarm_supervisor.sv */
`timescale 1ns/1ps
`default_nettype none

// Operation
// - No-current alarm: contactor 10 s, no current 3 s
// - Clear no-current when off or current present
// - Third occurrence locks pump; operator clears
// - Lockout alarm held until operator clears
// - Locked pump never gets its contactor energised
// - Water: low leaving alarm at 10 C, 3 s
// - Glycol: low leaving alarm at 7.2 C, 3 s
// - Release above 13 or 10.2 C for 3 s
// - Release at once outside leaving temperature control
// - Emergency flag follows low leaving alarm
// - Low basin: drain closed, no float 5 min
// - Low basin release: float true 3 s
// - High basin: high float true 5 min
// - High basin release: high float false 3 s
// - Drain alarm: valve open, float true 45 min
// - Drain alarm release: float false 3 s
module cooler_alarm_supervisor
  import cooler_alarm_pkg::*;
#(
  parameter int unsigned PUMPS = cooler_alarm_pkg::NUM_PUMPS,
  parameter int unsigned TICK_DIV = cooler_alarm_pkg::TICK_CYCLES
) (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Pumps
  input wire logic [PUMPS-1:0] pump_contact,
  input wire logic [PUMPS-1:0] pump_current,
  input wire logic [PUMPS-1:0] pump_start,
  input wire logic [PUMPS-1:0] lockout_clear,
  output logic [PUMPS-1:0] pump_run,
  output logic [PUMPS-1:0] no_current_alarm,
  output logic [PUMPS-1:0] lockout_alarm,
  output logic [PUMPS-1:0] no_current_event,
  output logic [PUMPS*cooler_alarm_pkg::OCC_W-1:0] lockout_count,
  // Sump
  input wire cooler_alarm_pkg::sump_in_t sump,
  // Leaving fluid
  input wire logic signed [cooler_alarm_pkg::TEMP_W-1:0] leaving_temp,
  input wire cooler_alarm_pkg::control_type_t control_type,
  input wire cooler_alarm_pkg::fluid_type_t fluid_type,
  // Alarm summary
  output cooler_alarm_pkg::alarm_t alarms,
  output logic emergency_flag,
  output logic general_alarm
);

  import cooler_alarm_pkg::*;

  // ***********************************************************
  // Millisecond enable
  // ***********************************************************
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_DIV - 1);

  logic [DIV_W-1:0] div_reg;
  logic tick;

  always_ff @(posedge clock) begin
    if (sys_rst || div_reg == DIV_LAST) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + 1'b1;
    end
  end

  assign tick = (div_reg == DIV_LAST);

  // ***********************************************************
  // Helpers
  // ***********************************************************
  function automatic logic at_or_below(
    input logic signed [TEMP_W-1:0] value,
    input logic signed [TEMP_W-1:0] limit
  );
    at_or_below = (value <= limit);
  endfunction

  // ***********************************************************
  // Pump no-current and lockout
  // ***********************************************************
  logic [PUMPS-1:0] on_done;
  logic [PUMPS-1:0] nocur_done;
  logic [PUMPS-1:0] nc_reg;
  logic [PUMPS-1:0] lock_reg;
  logic [PUMPS-1:0] run_reg;
  logic [PUMPS-1:0] event_reg;
  logic [OCC_W-1:0] occ_reg [PUMPS];

  genvar p;
  generate
    for (p = 0; p < PUMPS; p++) begin : g_pump
      logic nc_set;
      logic nc_clear;
      logic occur;
      logic lock_set;

      hold_timer #(
        .W(TMR_W)
      ) u_on_timer (
        .clock(clock),
        .sys_rst(sys_rst),
        .tick(tick),
        .cond(pump_contact[p]),
        .limit(PUMP_ON_TICKS),
        .done(on_done[p])
      );

      hold_timer #(
        .W(TMR_W)
      ) u_nocur_timer (
        .clock(clock),
        .sys_rst(sys_rst),
        .tick(tick),
        .cond(!pump_current[p]),
        .limit(NO_CURRENT_TICKS),
        .done(nocur_done[p])
      );

      assign nc_set = on_done[p] && nocur_done[p];
      assign nc_clear = !pump_contact[p] ||
        (pump_contact[p] && pump_current[p]);
      assign occur = nc_set && !nc_reg[p];
      assign lock_set = occur && (occ_reg[p] == OCC_LOCKOUT - 2'h1);

      always_ff @(posedge clock) begin
        if (sys_rst) begin
          nc_reg[p] <= 1'b0;
        end else if (nc_set) begin
          nc_reg[p] <= 1'b1;
        end else if (nc_clear) begin
          nc_reg[p] <= 1'b0;
        end
      end

      // An occurrence in the clearing cycle still counts; a third one wins.
      always_ff @(posedge clock) begin
        if (sys_rst) begin
          occ_reg[p] <= OCC_RESET;
        end else if (lockout_clear[p]) begin
          occ_reg[p] <= lock_set ? OCC_LOCKOUT :
            (occur ? OCC_RESET + 2'h1 : OCC_RESET);
        end else if (occur && occ_reg[p] != OCC_LOCKOUT) begin
          occ_reg[p] <= occ_reg[p] + 2'h1;
        end
      end

      always_ff @(posedge clock) begin
        if (sys_rst) begin
          lock_reg[p] <= 1'b0;
        end else if (lock_set) begin
          lock_reg[p] <= 1'b1;
        end else if (lockout_clear[p]) begin
          lock_reg[p] <= 1'b0;
        end
      end

      always_ff @(posedge clock) begin
        if (sys_rst) begin
          run_reg[p] <= 1'b0;
          event_reg[p] <= 1'b0;
        end else begin
          run_reg[p] <= pump_start[p] && !lock_reg[p] &&
            !lock_set;
          event_reg[p] <= occur;
        end
      end

      assign lockout_count[p*OCC_W +: OCC_W] = occ_reg[p];

      a_nocur_cause: assert property (@(posedge clock) disable iff (sys_rst)
        $rose(nc_reg[p]) |-> $past(pump_contact[p]) &&
          !$past(pump_current[p]))
        else $error("no-current alarm without its cause");

      a_nocur_clear: assert property (@(posedge clock) disable iff (sys_rst)
        nc_reg[p] && !pump_contact[p] |=> !nc_reg[p])
        else $error("no-current alarm kept with contactor off");

      a_lock_count: assert property (@(posedge clock) disable iff (sys_rst)
        $rose(lock_reg[p]) |-> occ_reg[p] == OCC_LOCKOUT)
        else $error("lockout before third occurrence");

      a_lock_hold: assert property (@(posedge clock) disable iff (sys_rst)
        lock_reg[p] && !lockout_clear[p] |=> lock_reg[p])
        else $error("lockout dropped without operator");

      a_lock_run: assert property (@(posedge clock) disable iff (sys_rst)
        lock_reg[p] |-> !run_reg[p] ##1 !run_reg[p] || !lock_reg[p])
        else $error("locked pump energised");
    end
  endgenerate

  assign pump_run = run_reg;
  assign no_current_alarm = nc_reg;
  assign lockout_alarm = lock_reg;
  assign no_current_event = event_reg;

  // ***********************************************************
  // Low leaving fluid temperature
  // ***********************************************************
  llt_state_t llt_state;
  logic leaving_ctrl;
  logic trip_cond;
  logic rel_cond;
  logic trip_done;
  logic rel_done;

  assign leaving_ctrl = (control_type == CT_LEAVING_TEMP);

  always_comb begin
    if (fluid_type == FLUID_GLYCOL) begin
      trip_cond = leaving_ctrl &&
        at_or_below(leaving_temp, GLYCOL_TRIP);
      rel_cond = leaving_ctrl &&
        !at_or_below(leaving_temp, GLYCOL_RELEASE);
    end else begin
      trip_cond = leaving_ctrl &&
        at_or_below(leaving_temp, WATER_TRIP);
      rel_cond = leaving_ctrl &&
        !at_or_below(leaving_temp, WATER_RELEASE);
    end
  end

  hold_timer #(
    .W(TMR_W)
  ) u_trip_timer (
    .clock(clock),
    .sys_rst(sys_rst),
    .tick(tick),
    .cond(trip_cond),
    .limit(LOW_TEMP_TICKS),
    .done(trip_done)
  );

  hold_timer #(
    .W(TMR_W)
  ) u_rel_timer (
    .clock(clock),
    .sys_rst(sys_rst),
    .tick(tick),
    .cond(rel_cond),
    .limit(RELEASE_TICKS),
    .done(rel_done)
  );

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      llt_state <= LLT_NORMAL;
    end else begin
      case (llt_state)
        LLT_NORMAL: begin
          if (trip_done) begin
            llt_state <= LLT_ALARM;
          end
        end
        LLT_ALARM: begin
          if (!leaving_ctrl) begin
            llt_state <= LLT_NORMAL;
          end else if (rel_done) begin
            llt_state <= LLT_NORMAL;
          end
        end
        default: begin
          llt_state <= LLT_NORMAL;
        end
      endcase
    end
  end

  a_llt_cause: assert property (@(posedge clock) disable iff (sys_rst)
    $rose(llt_state == LLT_ALARM) |-> $past(trip_cond, 1))
    else $error("low leaving alarm without cold fluid");

  a_llt_ctrl: assert property (@(posedge clock) disable iff (sys_rst)
    !leaving_ctrl |=> llt_state == LLT_NORMAL)
    else $error("low leaving alarm outside its control type");

  // ***********************************************************
  // Sump level and drain valve
  // ***********************************************************
  logic low_basin_reg;
  logic high_basin_reg;
  logic drain_reg;
  logic lb_set;
  logic lb_rel;
  logic hb_set;
  logic hb_rel;
  logic dv_set;
  logic dv_rel;

  hold_timer #(
    .W(TMR_W)
  ) u_lb_set (
    .clock(clock),
    .sys_rst(sys_rst),
    .tick(tick),
    .cond(!sump.drain_open && !sump.low_float),
    .limit(BASIN_TICKS),
    .done(lb_set)
  );

  hold_timer #(
    .W(TMR_W)
  ) u_float_true (
    .clock(clock),
    .sys_rst(sys_rst),
    .tick(tick),
    .cond(sump.low_float),
    .limit(RELEASE_TICKS),
    .done(lb_rel)
  );

  hold_timer #(
    .W(TMR_W)
  ) u_hb_set (
    .clock(clock),
    .sys_rst(sys_rst),
    .tick(tick),
    .cond(sump.high_float),
    .limit(BASIN_TICKS),
    .done(hb_set)
  );

  hold_timer #(
    .W(TMR_W)
  ) u_hb_rel (
    .clock(clock),
    .sys_rst(sys_rst),
    .tick(tick),
    .cond(!sump.high_float),
    .limit(RELEASE_TICKS),
    .done(hb_rel)
  );

  hold_timer #(
    .W(TMR_W)
  ) u_dv_set (
    .clock(clock),
    .sys_rst(sys_rst),
    .tick(tick),
    .cond(sump.drain_open && sump.low_float),
    .limit(DRAIN_TICKS),
    .done(dv_set)
  );

  hold_timer #(
    .W(TMR_W)
  ) u_float_false (
    .clock(clock),
    .sys_rst(sys_rst),
    .tick(tick),
    .cond(!sump.low_float),
    .limit(RELEASE_TICKS),
    .done(dv_rel)
  );

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      low_basin_reg <= 1'b0;
    end else if (lb_set) begin
      low_basin_reg <= 1'b1;
    end else if (lb_rel) begin
      low_basin_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      high_basin_reg <= 1'b0;
    end else if (hb_set) begin
      high_basin_reg <= 1'b1;
    end else if (hb_rel) begin
      high_basin_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      drain_reg <= 1'b0;
    end else if (dv_set) begin
      drain_reg <= 1'b1;
    end else if (dv_rel) begin
      drain_reg <= 1'b0;
    end
  end

  a_lb_cause: assert property (@(posedge clock) disable iff (sys_rst)
    $rose(low_basin_reg) |-> $past(!sump.drain_open && !sump.low_float))
    else $error("low basin alarm without its cause");

  a_hb_cause: assert property (@(posedge clock) disable iff (sys_rst)
    $rose(high_basin_reg) |-> $past(sump.high_float))
    else $error("high basin alarm without high float");

  a_dv_cause: assert property (@(posedge clock) disable iff (sys_rst)
    $rose(drain_reg) |-> $past(sump.drain_open && sump.low_float))
    else $error("drain valve alarm without its cause");

  // ***********************************************************
  // Alarm summary
  // ***********************************************************
  assign alarms.low_leaving = (llt_state == LLT_ALARM);
  assign alarms.low_basin = low_basin_reg;
  assign alarms.high_basin = high_basin_reg;
  assign alarms.drain_valve = drain_reg;
  assign emergency_flag = (llt_state == LLT_ALARM);
  assign general_alarm = (|alarms) || (|nc_reg) || (|lock_reg);

  a_emerg_flag: assert property (@(posedge clock) disable iff (sys_rst)
    alarms.low_leaving |-> emergency_flag && general_alarm)
    else $error("emergency flag missing with low leaving alarm");

  a_general_any: assert property (@(posedge clock) disable iff (sys_rst)
    $rose(low_basin_reg || high_basin_reg || drain_reg) |-> general_alarm)
    else $error("general alarm missing");

endmodule

`default_nettype wire

/* File: shared/cooler_alarm_pkg.sv */
package cooler_alarm_pkg;

  // ***********************************************************
  // Clock and time base
  // ***********************************************************
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned CLK_PERIOD_NS = 5;
  // Timers advance on a one millisecond enable.
  localparam int unsigned TICK_MS = 1;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned DIV_W = 28;

  // ***********************************************************
  // Qualifying durations
  // ***********************************************************
  localparam int unsigned PUMP_ON_S = 10;
  localparam int unsigned NO_CURRENT_S = 3;
  localparam int unsigned LOW_TEMP_S = 3;
  localparam int unsigned RELEASE_S = 3;
  localparam int unsigned BASIN_MIN = 5;
  localparam int unsigned DRAIN_MIN = 45;

  localparam int unsigned TMR_W = 22;
  localparam logic [TMR_W-1:0] PUMP_ON_TICKS =
    TMR_W'(PUMP_ON_S * 1000 / TICK_MS);
  localparam logic [TMR_W-1:0] NO_CURRENT_TICKS =
    TMR_W'(NO_CURRENT_S * 1000 / TICK_MS);
  localparam logic [TMR_W-1:0] LOW_TEMP_TICKS =
    TMR_W'(LOW_TEMP_S * 1000 / TICK_MS);
  localparam logic [TMR_W-1:0] RELEASE_TICKS =
    TMR_W'(RELEASE_S * 1000 / TICK_MS);
  localparam logic [TMR_W-1:0] BASIN_TICKS =
    TMR_W'(BASIN_MIN * 60 * 1000 / TICK_MS);
  localparam logic [TMR_W-1:0] DRAIN_TICKS =
    TMR_W'(DRAIN_MIN * 60 * 1000 / TICK_MS);

  // ***********************************************************
  // Pump lockout
  // ***********************************************************
  localparam int unsigned NUM_PUMPS = 2;
  localparam int unsigned OCC_W = 2;
  localparam logic [OCC_W-1:0] OCC_RESET = 2'h0;
  localparam logic [OCC_W-1:0] OCC_LOCKOUT = 2'h3;

  // ***********************************************************
  // Temperature thresholds, signed tenths of a degree Celsius
  // ***********************************************************
  localparam int unsigned TEMP_W = 16;
  localparam logic signed [TEMP_W-1:0] WATER_TRIP = 16'sh0064;
  localparam logic signed [TEMP_W-1:0] GLYCOL_TRIP = 16'sh0048;
  localparam logic signed [TEMP_W-1:0] WATER_RELEASE = 16'sh0082;
  localparam logic signed [TEMP_W-1:0] GLYCOL_RELEASE = 16'sh0066;

  // ***********************************************************
  // Types
  // ***********************************************************
  typedef enum logic [1:0] {
    CT_LEAVING_TEMP,
    CT_CUSTOMER_SIGNAL,
    CT_OTHER_A,
    CT_OTHER_B
  } control_type_t;

  typedef enum logic {
    FLUID_WATER,
    FLUID_GLYCOL
  } fluid_type_t;

  typedef enum {
    LLT_NORMAL,
    LLT_ALARM
  } llt_state_t;

  typedef struct packed {
    logic low_float;
    logic high_float;
    logic drain_open;
  } sump_in_t;

  typedef struct packed {
    logic low_leaving;
    logic low_basin;
    logic high_basin;
    logic drain_valve;
  } alarm_t;

endpackage

/* File: rtl/hold_timer.sv */
`timescale 1ns/1ps
`default_nettype none

// Reports done once cond has held for more than limit ticks.
module hold_timer #(
  parameter int unsigned W = 22
) (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Timing
  input wire logic tick,
  input wire logic cond,
  input wire logic [W-1:0] limit,
  // Result
  output logic done
);

  logic [W:0] count_reg;
  logic full;

  // One tick beyond the limit so a partial first tick never shortens it.
  assign full = (count_reg > {1'b0, limit});

  always_ff @(posedge clock) begin
    if (sys_rst || !cond) begin
      count_reg <= '0;
    end else if (tick && !full) begin
      count_reg <= count_reg + 1'b1;
    end
  end

  assign done = cond && full;

endmodule

`default_nettype wire

/* File: dv/pump_plant_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ***********************************************************
// Pump contactor and current switch model
// ***********************************************************
// The contactor follows the run drive one or two cycles later.
// The current switch reads true while the contactor is closed,
// unless the bench commands a dry-running pump fault.
module pump_plant_model #(
  parameter int unsigned PUMPS = 2
) (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Bench control
  input wire logic slow,
  input wire logic [PUMPS-1:0] pump_fail,
  // Device side
  input wire logic [PUMPS-1:0] pump_run,
  output logic [PUMPS-1:0] pump_contact,
  output logic [PUMPS-1:0] pump_current
);
  logic [PUMPS-1:0] pull_in_reg;
  logic [PUMPS-1:0] contact_reg;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pull_in_reg <= '0;
      contact_reg <= '0;
    end else begin
      pull_in_reg <= pump_run;
      contact_reg <= slow ? pull_in_reg : pump_run;
    end
  end

  assign pump_contact = contact_reg;
  assign pump_current = contact_reg & ~pump_fail;
endmodule

`default_nettype wire

/* File: dv/cooler_alarm_supervisor_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module cooler_alarm_supervisor_tb_top;
  import cooler_alarm_pkg::*;

  localparam int unsigned TDIV = 2;
  localparam int LIMIT = 100000;

  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic slow = 1'b1;
  logic [1:0] pump_start = 2'h0;
  logic [1:0] lockout_clear = 2'h0;
  logic [1:0] pump_fail = 2'h0;
  logic [1:0] pump_run;
  logic [1:0] no_current_alarm;
  logic [1:0] lockout_alarm;
  logic [1:0] no_current_event;
  logic [1:0] pump_contact;
  logic [1:0] pump_current;
  logic [3:0] lockout_count;
  sump_in_t sump = '{low_float: 1'b1, high_float: 1'b0, drain_open: 1'b0};
  logic signed [TEMP_W-1:0] leaving_temp = 16'sh00c8;
  control_type_t control_type = CT_CUSTOMER_SIGNAL;
  fluid_type_t fluid_type = FLUID_WATER;
  alarm_t alarms;
  logic emergency_flag;
  logic general_alarm;
  int num_errors = 0;
  int cmp_count = 0;
  int cycles = 0;

  always #2.5 clock = ~clock;

  cooler_alarm_supervisor #(.PUMPS(2), .TICK_DIV(TDIV)) i_dut (
    .clock(clock),
    .sys_rst(sys_rst),
    .pump_contact(pump_contact),
    .pump_current(pump_current),
    .pump_start(pump_start),
    .lockout_clear(lockout_clear),
    .pump_run(pump_run),
    .no_current_alarm(no_current_alarm),
    .lockout_alarm(lockout_alarm),
    .no_current_event(no_current_event),
    .lockout_count(lockout_count),
    .sump(sump),
    .leaving_temp(leaving_temp),
    .control_type(control_type),
    .fluid_type(fluid_type),
    .alarms(alarms),
    .emergency_flag(emergency_flag),
    .general_alarm(general_alarm)
  );

  pump_plant_model #(.PUMPS(2)) i_plant (
    .clock(clock),
    .sys_rst(sys_rst),
    .slow(slow),
    .pump_fail(pump_fail),
    .pump_run(pump_run),
    .pump_contact(pump_contact),
    .pump_current(pump_current)
  );

  // ***********************************************************
  // Checking helpers
  // ***********************************************************
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic probe(input int sel);
    case (sel)
      0: return no_current_alarm[0];
      1: return alarms.low_leaving;
      default: return lockout_alarm[0];
    endcase
  endfunction

  // Waits for the watched alarm to reach lvl within hi edges, not before lo.
  task automatic wait_lvl(input int sel, input logic lvl, input int lo,
                          input int hi);
    int n;
    n = 0;
    while (probe(sel) !== lvl && n < hi) begin
      @(posedge clock);
      n++;
    end
    check(32'(probe(sel) === lvl && n >= lo), 32'h1);
  endtask

  task automatic hold_lvl(input int sel, input logic lvl, input int n);
    logic ok;
    ok = 1'b1;
    repeat (n) begin
      @(posedge clock);
      if (probe(sel) !== lvl) ok = 1'b0;
    end
    check(32'(ok), 32'h1);
  endtask

  always @(posedge clock) begin
    cycles++;
    if (cycles == LIMIT) begin
      num_errors++;
      close_out();
    end
  end

  // ***********************************************************
  // Test sequence
  // ***********************************************************
  initial begin
    repeat (3) @(posedge clock);
    sys_rst <= 1'b0;
    // Pump 1 runs healthy through the whole pump test.
    pump_start <= 2'h3;
    pump_fail <= 2'h1;
    wait_lvl(0, 1'b1, 20000, 20016);
    check(32'(lockout_count[1:0]), 32'h1);
    // The event pulse rises with the alarm and lasts one cycle.
    check(32'(no_current_event[0]), 32'h1);
    check(32'(general_alarm), 32'h1);
    @(posedge clock);
    check(32'(no_current_event[0]), 32'h0);
    pump_fail <= 2'h0;
    wait_lvl(0, 1'b0, 1, 3);
    // The no-current qualifier drops before completing, then restarts.
    pump_fail <= 2'h1;
    repeat (4000) @(posedge clock);
    pump_fail <= 2'h0;
    repeat (5) @(posedge clock);
    pump_fail <= 2'h1;
    wait_lvl(0, 1'b1, 6000, 6012);
    check(32'(lockout_count[1:0]), 32'h2);
    check(32'(lockout_alarm[0]), 32'h0);
    pump_fail <= 2'h0;
    wait_lvl(0, 1'b0, 1, 3);
    pump_fail <= 2'h1;
    wait_lvl(2, 1'b1, 6000, 6012);
    check(32'(lockout_count[1:0]), 32'h3);
    @(posedge clock);
    check(32'(pump_run[0]), 32'h0);
    wait_lvl(0, 1'b0, 1, 5);
    repeat (50) @(posedge clock);
    check(32'(lockout_alarm[0]), 32'h1);
    check(32'(pump_run[0]), 32'h0);
    check(32'(general_alarm), 32'h1);
    pump_fail <= 2'h0;
    lockout_clear <= 2'h1;
    @(posedge clock);
    lockout_clear <= 2'h0;
    wait_lvl(2, 1'b0, 1, 3);
    check(32'(lockout_count[1:0]), 32'h0);
    repeat (3) @(posedge clock);
    check(32'(pump_run[0]), 32'h1);
    check(32'({no_current_alarm[1], lockout_count[3:2]}), 32'h0);
    $display("test pump lockout done");

    pump_start <= 2'h0;
    control_type <= CT_LEAVING_TEMP;
    leaving_temp <= 16'sh0064;
    wait_lvl(1, 1'b1, 6000, 6012);
    check(32'(emergency_flag), 32'h1);
    check(32'(general_alarm), 32'h1);
    leaving_temp <= 16'sh0082;
    hold_lvl(1, 1'b1, 6100);
    leaving_temp <= 16'sh0083;
    wait_lvl(1, 1'b0, 6000, 6012);
    check(32'(emergency_flag), 32'h0);
    check(32'(general_alarm), 32'h0);
    fluid_type <= FLUID_GLYCOL;
    leaving_temp <= 16'sh0049;
    hold_lvl(1, 1'b0, 6100);
    leaving_temp <= 16'sh0048;
    wait_lvl(1, 1'b1, 6000, 6012);
    // Every other control type releases at once.
    for (int i = 1; i < 4; i++) begin
      control_type <= control_type_t'(i);
      wait_lvl(1, 1'b0, 1, 3);
      control_type <= CT_LEAVING_TEMP;
      if (i < 3) wait_lvl(1, 1'b1, 6000, 6012);
    end
    check(32'({alarms.low_basin, alarms.high_basin, alarms.drain_valve}),
          32'h0);
    $display("test leaving fluid done");
    close_out();
  end
endmodule

`default_nettype wire
